// >>> core/crp_regs.vh
// Register offsets, field positions, reset values and codes for the collision/page block
`ifndef CRP_REGS_VH
`define CRP_REGS_VH

// Register indices as printed; byte address is four times the index
`define CRP_IDX_COLL 6'h0e
`define CRP_IDX_PAGE 6'h10
`define CRP_IDX_MODE 6'h11
`define CRP_IDX_IRQ_STAT 6'h20
`define CRP_IDX_IRQ_EN 6'h21
`define CRP_IDX_IRQ_CLR 6'h22
`define CRP_IDX_CTRL 6'h23

// Collision register fields
`define CRP_COLL_KEEP_BIT 7
`define CRP_COLL_INVALID_BIT 5
`define CRP_COLL_POS_W 5
`define CRP_COLL_POS_MAX 6'd32

// Page register fields
`define CRP_PAGE_USE_BIT 7
`define CRP_PAGE_BITS_W 2

// Mode register fields
`define CRP_MODE_TXWAIT_BIT 5
`define CRP_MODE_DETOFF_BIT 2

// Reset values
`define CRP_COLL_RST 8'ha0
`define CRP_PAGE_RST 8'h00
`define CRP_MODE_RST 8'h3b

// CRC preset codes 00..11
`define CRP_CRC_PRE0 16'h0000
`define CRP_CRC_PRE1 16'h6363
`define CRP_CRC_PRE2 16'ha671
`define CRP_CRC_PRE3 16'hffff

// Interrupt status bits
`define CRP_IRQ_COLL_BIT 0
`define CRP_IRQ_FRAME_BIT 1
`define CRP_IRQ_W 2

// AXI responses
`define CRP_RESP_OKAY 2'b00
`define CRP_RESP_SLVERR 2'b10

`endif

// >>> core/crp_coll_track.v
// Tracks the first collision of a received frame and masks later bits
`timescale 1ns/1ns
`include "crp_regs.vh"

module crp_coll_track (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst_n,
  // Receiver side
  input wire i_rx_start,
  input wire i_rx_bit_valid,
  input wire i_rx_bit,
  input wire i_rx_collision,
  input wire i_keep_bits,
  // Results
  output wire o_rx_bit_valid,
  output wire o_rx_bit,
  output wire [`CRP_COLL_POS_W-1:0] o_position,
  output wire o_invalid,
  output wire o_first_coll
);

  reg [5:0] bit_cnt_r;
  reg seen_r;
  reg [`CRP_COLL_POS_W-1:0] pos_r;
  reg invalid_r;
  reg [6:0] pos_nxt;

  // Data bit number this bit carries, counting from one; one bit wider so a
  // saturated count cannot wrap back into the encodable range
  always @* begin
    pos_nxt = {1'b0, bit_cnt_r} + 7'd1;
  end

  assign o_first_coll = i_rx_bit_valid && i_rx_collision && !seen_r;

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_cnt_r <= 6'd0;
      seen_r <= 1'b0;
      pos_r <= {`CRP_COLL_POS_W{1'b0}};
      invalid_r <= 1'b1;
    end else if (i_rx_start) begin
      bit_cnt_r <= 6'd0;
      seen_r <= 1'b0;
      pos_r <= {`CRP_COLL_POS_W{1'b0}};
      invalid_r <= 1'b1;
    end else if (i_rx_bit_valid) begin
      if (bit_cnt_r != 6'h3f) begin
        bit_cnt_r <= pos_nxt[5:0];
      end
      if (o_first_coll) begin
        seen_r <= 1'b1;
        pos_r <= pos_nxt[`CRP_COLL_POS_W-1:0];
        invalid_r <= (pos_nxt > {1'b0, `CRP_COLL_POS_MAX});
      end
    end
  end

  assign o_rx_bit = i_rx_bit & (i_keep_bits | ~seen_r);
  assign o_rx_bit_valid = i_rx_bit_valid;
  assign o_position = pos_r;
  assign o_invalid = invalid_r;

endmodule

// >>> core/crp_top.v
// Collision report, page select and general mode registers behind AXI4-Lite
//
// Behaviour
// - With keep-bits cleared, every received bit after a collision is forced to zero.
// - The invalid flag is set when no collision occurred or it lies past bit 32.
// - A five-bit field holds the data-bit position of the first collision.
// - Bit 1 reads 01h, bit 8 reads 08h and bit 32 reads 00h.
// - The collision register reads 1 in bit 7, 0 in bit 6 and 1 in bit 5 after reset.
// - With upper-address select set, the page bits become address bits A5 and A4.
// - With paging on, the low address bits come from the active host address.
// - With upper-address select clear, the latch alone forms the whole address.
// - The page register sits at 10h, resets to zero and reads bits 6 to 2 as zero.
// - The mode register sits at 11h, is fully read/write and resets to 3Bh.
// - The CRC preset code selects 0000, 6363, A671 or FFFF, overridden during RF.
// - With wait-for-field set, transmit starts in reader or initiator only with field on.
// - With detector-off set, the mode detector stays off; else only during auto collision.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "crp_regs.vh"

module crp_top #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst_n,
  // AXI4-Lite write address
  input wire [ADDR_W-1:0] i_awaddr,
  input wire i_awvalid,
  output reg o_awready,
  // AXI4-Lite write data
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output reg o_wready,
  // AXI4-Lite write response
  output reg [1:0] o_bresp,
  output reg o_bvalid,
  input wire i_bready,
  // AXI4-Lite read address
  input wire [ADDR_W-1:0] i_araddr,
  input wire i_arvalid,
  output reg o_arready,
  // AXI4-Lite read data
  output reg [31:0] o_rdata,
  output reg [1:0] o_rresp,
  output reg o_rvalid,
  input wire i_rready,
  // Receiver collision detector
  input wire i_rx_start,
  input wire i_rx_bit_valid,
  input wire i_rx_bit,
  input wire i_rx_collision,
  input wire i_rx_end,
  // Device state
  input wire i_rf_framing_crc_sel_valid,
  input wire [1:0] i_rf_framing_crc_sel,
  input wire i_tx_request,
  input wire i_reader_or_initiator,
  input wire i_rf_field_on,
  input wire i_automatic_collision_command,
  // Host address path for paged access
  input wire i_host_addr_valid,
  input wire [5:0] i_addr_pins,
  input wire [5:0] i_addr_latch,
  input wire i_use_addr_pins,
  // Outputs to the device core
  output reg o_rx_bit_valid,
  output reg o_rx_bit,
  output reg [5:0] o_reg_addr,
  output reg o_reg_addr_valid,
  output reg [15:0] o_crc_initial_value,
  output reg o_tx_start,
  output reg o_mode_detector_en,
  output reg o_irq
);

  // One-hot states shared by both bus channels
  localparam ST_IDLE = 2'b01;
  localparam ST_RESP = 2'b10;
  localparam [7:0] COLL_RST = `CRP_COLL_RST;

  reg [1:0] wst_r;
  reg [1:0] rst_r;
  reg aw_got_r;
  reg w_got_r;
  reg [ADDR_W-1:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg keep_bits_r;
  reg [7:0] page_r;
  reg [7:0] mode_r;
  reg [`CRP_IRQ_W-1:0] irq_stat_r;
  reg [`CRP_IRQ_W-1:0] irq_en_r;
  reg [7:0] rdata_nxt;
  reg rd_ok_nxt;
  reg wr_ok_nxt;
  reg [15:0] crc_nxt;
  reg [`CRP_IRQ_W-1:0] irq_set_nxt;
  reg [`CRP_IRQ_W-1:0] irq_clr_nxt;
  reg [5:0] addr_nxt;

  wire [5:0] wr_idx;
  wire [5:0] rd_idx;
  wire do_write;
  wire trk_bit_valid;
  wire trk_bit;
  wire [`CRP_COLL_POS_W-1:0] trk_pos;
  wire trk_invalid;
  wire trk_first;
  wire [7:0] coll_rd;

  assign wr_idx = awaddr_r[7:2];
  assign rd_idx = i_araddr[7:2];
  assign do_write = (wst_r == ST_IDLE) && aw_got_r && w_got_r;
  assign coll_rd = {keep_bits_r, 1'b0, trk_invalid, trk_pos};

  // Collision tracker
  crp_coll_track u_track (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_rx_start(i_rx_start),
    .i_rx_bit_valid(i_rx_bit_valid),
    .i_rx_bit(i_rx_bit),
    .i_rx_collision(i_rx_collision),
    .i_keep_bits(keep_bits_r),
    .o_rx_bit_valid(trk_bit_valid),
    .o_rx_bit(trk_bit),
    .o_position(trk_pos),
    .o_invalid(trk_invalid),
    .o_first_coll(trk_first)
  );

  // Write address and data are captured independently, either order
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= {ADDR_W{1'b0}};
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= `CRP_RESP_OKAY;
      wst_r <= ST_IDLE;
    end else begin
      case (wst_r)
        ST_IDLE: begin
          if (i_awvalid && o_awready) begin
            awaddr_r <= i_awaddr;
            aw_got_r <= 1'b1;
            o_awready <= 1'b0;
          end
          if (i_wvalid && o_wready) begin
            wdata_r <= i_wdata;
            wstrb_r <= i_wstrb;
            w_got_r <= 1'b1;
            o_wready <= 1'b0;
          end
          if (do_write) begin
            o_bvalid <= 1'b1;
            o_bresp <= wr_ok_nxt ? `CRP_RESP_OKAY : `CRP_RESP_SLVERR;
            wst_r <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (i_bready) begin
            o_bvalid <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            wst_r <= ST_IDLE;
          end
        end
        default: begin
          wst_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Write decode; collision bits other than bit 7 are read-only
  always @* begin
    wr_ok_nxt = 1'b1;
    irq_clr_nxt = {`CRP_IRQ_W{1'b0}};
    if (wr_idx == `CRP_IDX_COLL) begin
      wr_ok_nxt = 1'b1;
    end else if (wr_idx == `CRP_IDX_PAGE) begin
      wr_ok_nxt = 1'b1;
    end else if (wr_idx == `CRP_IDX_MODE) begin
      wr_ok_nxt = 1'b1;
    end else if (wr_idx == `CRP_IDX_IRQ_STAT) begin
      wr_ok_nxt = 1'b1;
    end else if (wr_idx == `CRP_IDX_IRQ_EN) begin
      wr_ok_nxt = 1'b1;
    end else if (wr_idx == `CRP_IDX_IRQ_CLR) begin
      if (do_write && wstrb_r[0]) begin
        irq_clr_nxt = wdata_r[`CRP_IRQ_W-1:0];
      end
    end else begin
      wr_ok_nxt = 1'b0;
    end
  end

  // Register storage; writes to read-only fields are dropped
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      keep_bits_r <= COLL_RST[`CRP_COLL_KEEP_BIT];
      page_r <= `CRP_PAGE_RST;
      mode_r <= `CRP_MODE_RST;
      irq_en_r <= {`CRP_IRQ_W{1'b0}};
    end else if (do_write && wstrb_r[0]) begin
      if (wr_idx == `CRP_IDX_COLL) begin
        keep_bits_r <= wdata_r[`CRP_COLL_KEEP_BIT];
      end else if (wr_idx == `CRP_IDX_PAGE) begin
        page_r <= {wdata_r[`CRP_PAGE_USE_BIT], 5'b00000, wdata_r[1:0]};
      end else if (wr_idx == `CRP_IDX_MODE) begin
        mode_r <= wdata_r[7:0];
      end else if (wr_idx == `CRP_IDX_IRQ_EN) begin
        irq_en_r <= wdata_r[`CRP_IRQ_W-1:0];
      end
    end
  end

  // Sticky events: a new event wins over a clear in the same cycle
  always @* begin
    irq_set_nxt = {`CRP_IRQ_W{1'b0}};
    irq_set_nxt[`CRP_IRQ_COLL_BIT] = trk_first;
    irq_set_nxt[`CRP_IRQ_FRAME_BIT] = i_rx_end;
  end

  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat_r <= {`CRP_IRQ_W{1'b0}};
      o_irq <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr_nxt) | irq_set_nxt;
      o_irq <= |(((irq_stat_r & ~irq_clr_nxt) | irq_set_nxt) & irq_en_r);
    end
  end

  // Read decode; unmapped indices answer SLVERR with zero data
  always @* begin
    rdata_nxt = 8'h00;
    rd_ok_nxt = 1'b1;
    if (rd_idx == `CRP_IDX_COLL) begin
      rdata_nxt = coll_rd;
    end else if (rd_idx == `CRP_IDX_PAGE) begin
      rdata_nxt = page_r;
    end else if (rd_idx == `CRP_IDX_MODE) begin
      rdata_nxt = mode_r;
    end else if (rd_idx == `CRP_IDX_IRQ_STAT) begin
      rdata_nxt = {{(8-`CRP_IRQ_W){1'b0}}, irq_stat_r};
    end else if (rd_idx == `CRP_IDX_IRQ_EN) begin
      rdata_nxt = {{(8-`CRP_IRQ_W){1'b0}}, irq_en_r};
    end else if (rd_idx == `CRP_IDX_IRQ_CLR) begin
      rdata_nxt = 8'h00;
    end else begin
      rd_ok_nxt = 1'b0;
    end
  end

  // Read channel: address taken, data answered next cycle
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `CRP_RESP_OKAY;
      rst_r <= ST_IDLE;
    end else begin
      case (rst_r)
        ST_IDLE: begin
          if (i_arvalid) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= {24'h000000, rdata_nxt};
            o_rresp <= rd_ok_nxt ? `CRP_RESP_OKAY : `CRP_RESP_SLVERR;
            rst_r <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
            rst_r <= ST_IDLE;
          end
        end
        default: begin
          rst_r <= ST_IDLE;
        end
      endcase
    end
  end

  // CRC preset: RF framing overrides the software code
  always @* begin
    case (i_rf_framing_crc_sel_valid ? i_rf_framing_crc_sel : mode_r[1:0])
      2'b00: crc_nxt = `CRP_CRC_PRE0;
      2'b01: crc_nxt = `CRP_CRC_PRE1;
      2'b10: crc_nxt = `CRP_CRC_PRE2;
      default: crc_nxt = `CRP_CRC_PRE3;
    endcase
  end

  // Register address: paged or latch-only
  always @* begin
    addr_nxt = i_addr_latch;
    if (page_r[`CRP_PAGE_USE_BIT]) begin
      // page bits are A5 and A4
      addr_nxt[5:4] = page_r[1:0];
      // low bits from the active host
      addr_nxt[3:0] = i_use_addr_pins ? i_addr_pins[3:0] : i_addr_latch[3:0];
    end
  end

  // Registered core outputs; one cycle of latency on every path
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx_bit_valid <= 1'b0;
      o_rx_bit <= 1'b0;
      o_reg_addr <= 6'h00;
      o_reg_addr_valid <= 1'b0;
      o_crc_initial_value <= 16'h0000;
      o_tx_start <= 1'b0;
      o_mode_detector_en <= 1'b0;
    end else begin
      o_rx_bit_valid <= trk_bit_valid;
      o_rx_bit <= trk_bit;
      // latch alone when paging is off
      o_reg_addr <= addr_nxt;
      o_reg_addr_valid <= i_host_addr_valid;
      o_crc_initial_value <= crc_nxt;
      // hold start until the field is up
      o_tx_start <= i_tx_request &&
        !(mode_r[`CRP_MODE_TXWAIT_BIT] && i_reader_or_initiator && !i_rf_field_on);
      // detector gated by the off bit
      o_mode_detector_en <= i_automatic_collision_command && !mode_r[`CRP_MODE_DETOFF_BIT];
    end
  end

endmodule

// >>> verif/crp_top_chk.sv
// Concurrent checks on the ports of the collision/page register block
`timescale 1ns/1ns

module crp_top_chk (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst_n,
  // Register bus handshakes
  input wire i_arvalid,
  input wire o_arready,
  input wire [31:0] o_rdata,
  input wire o_rvalid,
  input wire i_rready,
  input wire o_awready,
  input wire o_wready,
  input wire o_bvalid,
  input wire i_bready,
  // Receive path and device state
  input wire i_rx_bit_valid,
  input wire i_rx_bit,
  input wire o_rx_bit_valid,
  input wire o_rx_bit,
  input wire i_rf_framing_crc_sel_valid,
  input wire [1:0] i_rf_framing_crc_sel,
  input wire [15:0] o_crc_initial_value,
  input wire i_automatic_collision_command,
  input wire o_mode_detector_en,
  input wire i_host_addr_valid,
  input wire o_reg_addr_valid
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  // Preset lookup kept local so the checker does not share design code
  function automatic [15:0] crc_of(input [1:0] c);
    case (c)
      2'h0: crc_of = 16'h0000;
      2'h1: crc_of = 16'h6363;
      2'h2: crc_of = 16'ha671;
      default: crc_of = 16'hffff;
    endcase
  endfunction

  property p_rhold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data not held");
  property p_bhold;
    o_bvalid && !i_bready |=> o_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rrise;
    $rose(o_rvalid) |-> $past(i_arvalid && o_arready);
  endproperty
  a_rrise: assert property (p_rrise) else $error("read answer without request");
  property p_bwait;
    $rose(o_bvalid) |-> !o_awready && !o_wready;
  endproperty
  a_bwait: assert property (p_bwait) else $error("write ready during response");
  property p_rxpass;
    i_rx_bit_valid |=> o_rx_bit_valid;
  endproperty
  a_rxpass: assert property (p_rxpass) else $error("received bit lost");
  property p_rxzero;
    i_rx_bit_valid && !i_rx_bit |=> !o_rx_bit;
  endproperty
  a_rxzero: assert property (p_rxzero) else $error("zero bit turned to one");
  property p_crc;
    i_rf_framing_crc_sel_valid |=> o_crc_initial_value == crc_of($past(i_rf_framing_crc_sel));
  endproperty
  a_crc: assert property (p_crc) else $error("wrong framing preset");
  property p_det;
    o_mode_detector_en |-> $past(i_automatic_collision_command);
  endproperty
  a_det: assert property (p_det) else $error("detector on outside auto collision");
  property p_addr;
    i_host_addr_valid |=> o_reg_addr_valid;
  endproperty
  a_addr: assert property (p_addr) else $error("register address not formed");

  // Main scenarios reached
  c_wr: cover property (o_bvalid && i_bready);
  c_rd: cover property (o_rvalid && i_rready);
  c_det: cover property (o_mode_detector_en);
endmodule

bind crp_top crp_top_chk chk_u (.*);

// >>> verif/crp_rx_model.sv
// Receiver model: frames of one-bits with collisions at a chosen bit
`timescale 1ns/1ns

module crp_rx_model (
  // Control from the bench
  input wire i_clk,
  input wire i_go,
  input wire [6:0] i_nbits,
  input wire [6:0] i_coll_at,
  // Receiver outputs
  output reg o_start,
  output reg o_bv,
  output reg o_bit,
  output reg o_coll,
  output reg o_end,
  output wire o_busy
);
  reg [6:0] n_r = 7'h00;
  reg act_r = 1'b0;
  assign o_busy = act_r;
  initial {o_start, o_bv, o_bit, o_coll, o_end} = 5'h00;

  // One bit every other cycle; the data line toggles between bits
  always @(posedge i_clk) begin
    o_start <= i_go;
    o_bv <= 1'b0;
    o_coll <= 1'b0;
    o_end <= 1'b0;
    o_bit <= ~o_bit;
    if (i_go) begin
      n_r <= 7'h00;
      act_r <= 1'b1;
    end else if (act_r && n_r == i_nbits) begin
      o_end <= 1'b1;
      act_r <= 1'b0;
    end else if (act_r && !o_bv) begin
      o_bv <= 1'b1;
      o_bit <= 1'b1;
      // second collision must not move the position
      o_coll <= i_coll_at != 7'h00 && (n_r + 7'h01 == i_coll_at || n_r - 7'h01 == i_coll_at);
      n_r <= n_r + 7'h01;
    end
  end
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the collision/page register block
`timescale 1ns/1ns

module tb_top;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_awaddr = '0, i_araddr = '0;
  logic [31:0] i_wdata = '0;
  logic [3:0] i_wstrb = '0;
  logic i_awvalid = '0, i_wvalid = '0, i_bready = '0, i_arvalid = '0, i_rready = '0;
  logic i_rf_framing_crc_sel_valid = '0, i_tx_request = '0, i_reader_or_initiator = '0;
  logic i_rf_field_on = '0, i_automatic_collision_command = '0, i_host_addr_valid = '0;
  logic i_use_addr_pins = '0, go = '0;
  logic [1:0] i_rf_framing_crc_sel = '0;
  logic [5:0] i_addr_pins = '0, i_addr_latch = '0;
  logic [6:0] nb = '0, ca = '0;
  wire i_rx_start, i_rx_bit_valid, i_rx_bit, i_rx_collision, i_rx_end, busy;
  wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_rx_bit_valid, o_rx_bit;
  wire o_reg_addr_valid, o_tx_start, o_mode_detector_en, o_irq;
  wire [1:0] o_bresp, o_rresp;
  wire [31:0] o_rdata;
  wire [5:0] o_reg_addr;
  wire [15:0] o_crc_initial_value;
  logic [15:0] crc_tab [4] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff};
  int error_cnt = 0, checked = 0, ones = 0;

  crp_top dut_u (.*);
  crp_rx_model rx_u (.i_clk(i_sys_clk), .i_go(go), .i_nbits(nb), .i_coll_at(ca),
    .o_start(i_rx_start), .o_bv(i_rx_bit_valid), .o_bit(i_rx_bit),
    .o_coll(i_rx_collision), .o_end(i_rx_end), .o_busy(busy));

  // Clock, watchdog and count of delivered one-bits per frame
  always #25 i_sys_clk = ~i_sys_clk;
  initial begin
    #(50 * 8000);
    error_cnt++;
    wrap_up;
  end
  always @(posedge i_sys_clk) begin
    if (go) ones <= 0;
    else if (o_rx_bit_valid && o_rx_bit) ones <= ones + 1;
  end

  task automatic cmp(input logic [31:0] g, e, input string m);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Response ready is raised late so the slave must hold its answer
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] er);
    int k;
    k = 0;
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= 4'h1;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      k++;
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      if (k == 3) i_bready <= 1'b1;
    end while (!(o_bvalid && i_bready) && k < 60);
    i_bready <= 1'b0;
    cmp(k < 60, 1, "write wait");
    cmp(o_bresp, er, "bresp");
    @(posedge i_sys_clk);
  endtask

  task automatic rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    int k;
    k = 0;
    i_araddr <= a;
    i_arvalid <= 1'b1;
    do begin
      @(posedge i_sys_clk);
      k++;
      if (o_arready) i_arvalid <= 1'b0;
      if (k == 2) i_rready <= 1'b1;
    end while (!(o_rvalid && i_rready) && k < 60);
    i_rready <= 1'b0;
    cmp(k < 60, 1, "read wait");
    cmp(o_rdata, ed, "rdata");
    cmp(o_rresp, er, "rresp");
    @(posedge i_sys_clk);
  endtask

  task automatic frame(input [6:0] n, input [6:0] c);
    int k;
    k = 0;
    nb <= n;
    ca <= c;
    go <= 1'b1;
    @(posedge i_sys_clk);
    go <= 1'b0;
    do begin
      @(posedge i_sys_clk);
      k++;
    end while (busy && k < 200);
    repeat (3) @(posedge i_sys_clk);
  endtask

  task automatic host(input [5:0] e);
    i_host_addr_valid <= 1'b1;
    @(posedge i_sys_clk);
    i_host_addr_valid <= 1'b0;
    @(posedge i_sys_clk);
    cmp(o_reg_addr, e, "reg addr");
  endtask

  task t_reset;
    rd(8'h38, 32'ha0, 2'h0);
    rd(8'h40, 32'h00, 2'h0);
    rd(8'h44, 32'h3b, 2'h0);
    wr(8'h38, 32'hff, 2'h0);
    rd(8'h38, 32'ha0, 2'h0);
    wr(8'h8c, 32'hff, 2'h2);
    rd(8'h8c, 32'h00, 2'h2);
    $display("test reset done");
  endtask

  task t_coll;
    frame(7'd40, 7'd1);
    rd(8'h38, 32'h81, 2'h0);
    cmp(ones, 40, "kept bits");
    frame(7'd40, 7'd8);
    rd(8'h38, 32'h88, 2'h0);
    cmp(o_rdata[5], 1'b0, "position usable");
    frame(7'd40, 7'd32);
    rd(8'h38, 32'h80, 2'h0);
    frame(7'd40, 7'd33);
    rd(8'h38, 32'ha1, 2'h0);
    frame(7'd40, 7'd0);
    rd(8'h38, 32'ha0, 2'h0);
    wr(8'h38, 32'h00, 2'h0);
    frame(7'd20, 7'd3);
    rd(8'h38, 32'h03, 2'h0);
    cmp(ones, 3, "cleared bits");
    wr(8'h38, 32'h80, 2'h0);
    $display("test collision done");
  endtask

  task t_page;
    i_addr_latch <= 6'h2a;
    i_addr_pins <= 6'h15;
    i_use_addr_pins <= 1'b1;
    host(6'h2a);
    wr(8'h40, 32'hff, 2'h0);
    rd(8'h40, 32'h83, 2'h0);
    host(6'h35);
    i_use_addr_pins <= 1'b0;
    host(6'h3a);
    wr(8'h40, 32'h00, 2'h0);
    $display("test page done");
  endtask

  task t_mode;
    wr(8'h44, 32'hff, 2'h0);
    rd(8'h44, 32'hff, 2'h0);
    for (int c = 0; c < 4; c++) begin
      wr(8'h44, c, 2'h0);
      cmp(o_crc_initial_value, crc_tab[c], "crc preset");
      i_rf_framing_crc_sel <= 2'(3 - c);
      i_rf_framing_crc_sel_valid <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      cmp(o_crc_initial_value, crc_tab[3 - c], "crc rf");
      i_rf_framing_crc_sel_valid <= 1'b0;
    end
    i_tx_request <= 1'b1;
    i_reader_or_initiator <= 1'b1;
    i_automatic_collision_command <= 1'b1;
    wr(8'h44, 32'h20, 2'h0);
    cmp(o_tx_start, 0, "tx no field");
    cmp(o_mode_detector_en, 1, "detector on");
    i_rf_field_on <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    cmp(o_tx_start, 1, "tx field");
    wr(8'h44, 32'h24, 2'h0);
    cmp(o_mode_detector_en, 0, "detector off");
    i_tx_request <= 1'b0;
    i_automatic_collision_command <= 1'b0;
    $display("test mode done");
  endtask

  task t_irq;
    wr(8'h88, 32'h3, 2'h0);
    rd(8'h80, 32'h0, 2'h0);
    wr(8'h84, 32'h1, 2'h0);
    cmp(o_irq, 0, "irq idle");
    frame(7'd10, 7'd4);
    cmp(o_irq, 1, "irq raised");
    rd(8'h80, 32'h3, 2'h0);
    wr(8'h84, 32'h0, 2'h0);
    cmp(o_irq, 0, "irq masked");
    wr(8'h84, 32'h2, 2'h0);
    cmp(o_irq, 1, "irq frame");
    wr(8'h88, 32'h3, 2'h0);
    rd(8'h80, 32'h0, 2'h0);
    cmp(o_irq, 0, "irq cleared");
    $display("test irq done");
  endtask

  // Reset for three cycles, then the scenarios in turn
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    t_reset;
    t_coll;
    t_page;
    t_mode;
    t_irq;
    wrap_up;
  end
endmodule
